// ===== core/nvm_host.sv
// module: host controller that drives flash erase and program through key and control writes
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module nvm_host (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic [3:0]                reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [15:0]                    reg_rdata,
  output nvm_host_pkg::dev_req_t         dev_req,
  input  wire logic                      dev_stall,
  output logic                           busy
);
  import nvm_host_pkg::*;

  // ************************************************************
  // software registers
  // ************************************************************
  logic [15:0] target;
  logic [7:0]  wdata;
  logic [7:0]  wdata2;
  logic        done;
  logic        violation;
  state_t      state;
  logic        op_erase;
  logic        op_pair;
  logic        pair_second;
  logic        bad_key;
  logic        stall_s1;
  logic        stall_s2;
  logic        seen_stall;
  logic [2:0]  wait_cnt;

  function automatic logic is_wide(input logic [15:0] a);
    is_wide = (a > SHORT_ADDR_MAX);
  endfunction : is_wide

  wire logic start = reg_wr && (reg_addr == ADDR_CTRL) && (state == ST_IDLE)
                     && |reg_wdata[2:0];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      target <= 16'h0000;
      wdata  <= 8'h00;
      wdata2 <= 8'h00;
    end else if (reg_wr && state == ST_IDLE) begin
      if (reg_addr == ADDR_TARGET) begin
        target <= reg_wdata;
      end else if (reg_addr == ADDR_DATA) begin
        wdata <= reg_wdata[7:0];
      end else if (reg_addr == ADDR_SECOND) begin
        wdata2 <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_TARGET) begin
        reg_rdata <= target;
      end else if (reg_addr == ADDR_DATA) begin
        reg_rdata <= {8'h00, wdata};
      end else if (reg_addr == ADDR_SECOND) begin
        reg_rdata <= {8'h00, wdata2};
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata <= {13'h0000, violation, done, busy};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ************************************************************
  // stall input synchroniser
  // ************************************************************
  // the stall comes from the device pins, so it is treated as foreign
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stall_s1 <= 1'b0;
      stall_s2 <= 1'b0;
    end else begin
      stall_s1 <= dev_stall;
      stall_s2 <= stall_s1;
    end
  end

  // a locked device never stalls, so the wait ends once the sync delay is covered
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wait_cnt <= 3'h0;
    end else if (state != ST_WAIT) begin
      wait_cnt <= 3'h0;
    end else if (wait_cnt != STALL_GRACE) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end

  // ************************************************************
  // sequence engine
  // ************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state       <= ST_IDLE;
      op_erase    <= 1'b0;
      op_pair     <= 1'b0;
      pair_second <= 1'b0;
      bad_key     <= 1'b0;
      seen_stall  <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            op_erase    <= reg_wdata[CTRL_GO_ERASE];
            op_pair     <= reg_wdata[CTRL_GO_PAIR];
            bad_key     <= reg_wdata[CTRL_BAD_KEY];
            pair_second <= 1'b0;
            state       <= ST_SCALE;
          end
        end
        ST_SCALE: state <= ST_CACHE;
        ST_CACHE: state <= ST_PSC;
        ST_PSC:   state <= ST_KEY1;
        ST_KEY1:  state <= ST_KEY2;
        ST_KEY2:  state <= ST_MEM;
        ST_MEM: begin
          seen_stall <= 1'b0;
          state      <= ST_WAIT;
        end
        ST_WAIT: begin
          // wait for the device stall to rise and fall again
          if (stall_s2) begin
            seen_stall <= 1'b1;
          end else if (seen_stall || wait_cnt == STALL_GRACE) begin
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (op_pair && !pair_second) begin
            pair_second <= 1'b1;
            state       <= ST_KEY1;
          end else begin
            state <= ST_PSC_OFF;
          end
        end
        ST_PSC_OFF: state <= ST_CCH_OFF;
        ST_CCH_OFF: state <= ST_IDLE;
        default:    state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done      <= 1'b0;
      violation <= 1'b0;
    end else begin
      if (start) begin
        done <= 1'b0;
      end else if (state == ST_CCH_OFF) begin
        done <= 1'b1;
      end
      // a wrong key locks the device until reset, so remember it
      if (state == ST_KEY1 && bad_key) begin
        violation <= 1'b1;
      end
    end
  end

  // ************************************************************
  // device access generation
  // ************************************************************
  // blank parts must first be loaded over the debug port; only software writes are issued here
  // the supply monitor stays under system software control, nothing here can switch it off
  logic [15:0] mem_addr;
  always_comb begin
    mem_addr = pair_second ? target + 16'h0001 : target;
    if (op_erase) begin
      mem_addr = target;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dev_req <= '0;
    end else begin
      dev_req <= '0;
      case (state)
        ST_SCALE: begin
          dev_req.wr   <= 1'b1;
          dev_req.sel  <= SEL_SCALE;
          dev_req.data <= SCALE_TIMING;
        end
        ST_CACHE: begin
          dev_req.wr   <= 1'b1;
          dev_req.sel  <= SEL_CACHE;
          dev_req.data <= op_pair ? CACHE_BLOCK : CACHE_OFF;
        end
        ST_PSC: begin
          dev_req.wr   <= 1'b1;
          dev_req.sel  <= SEL_PSC;
          dev_req.data <= op_erase ? PSC_ERASE : PSC_WRITE;
        end
        ST_KEY1: begin
          dev_req.wr   <= 1'b1;
          dev_req.sel  <= SEL_KEY;
          dev_req.data <= bad_key ? KEY_WRONG : KEY_FIRST;
        end
        ST_KEY2: begin
          dev_req.wr   <= 1'b1;
          dev_req.sel  <= SEL_KEY;
          dev_req.data <= KEY_SECOND;
        end
        ST_MEM: begin
          dev_req.wr   <= 1'b1;
          dev_req.sel  <= SEL_MEM;
          dev_req.wide <= is_wide(mem_addr);
          dev_req.addr <= mem_addr;
          dev_req.data <= pair_second ? wdata2 : wdata;
        end
        ST_PSC_OFF: begin
          dev_req.wr   <= 1'b1;
          dev_req.sel  <= SEL_PSC;
          dev_req.data <= PSC_OFF;
        end
        ST_CCH_OFF: begin
          dev_req.wr   <= 1'b1;
          dev_req.sel  <= SEL_CACHE;
          dev_req.data <= CACHE_OFF;
        end
        default: dev_req <= '0;
      endcase
    end
  end

  assign busy = (state != ST_IDLE);

  // ************************************************************
  // checks
  // ************************************************************
  a_key_order: assert property (@(posedge clock) disable iff (sys_rst)
    (dev_req.wr && dev_req.sel == SEL_KEY && dev_req.data == KEY_FIRST)
      |=> (dev_req.wr && dev_req.sel == SEL_KEY && dev_req.data == KEY_SECOND))
    else $error("second key does not follow first");
  a_key_before_mem: assert property (@(posedge clock) disable iff (sys_rst)
    (dev_req.wr && dev_req.sel == SEL_MEM) |-> ($past(dev_req.data) == KEY_SECOND))
    else $error("memory write without fresh keys");
  a_wide_addr: assert property (@(posedge clock) disable iff (sys_rst)
    (dev_req.wr && dev_req.sel == SEL_MEM && dev_req.addr > SHORT_ADDR_MAX) |-> dev_req.wide)
    else $error("short addressing above limit");
  a_scale_first: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_IDLE && start) |=> ##1 (dev_req.sel == SEL_SCALE && dev_req.data == SCALE_TIMING))
    else $error("timing enable not written first");
  a_enable_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_PSC_OFF) |=> (dev_req.sel == SEL_PSC && dev_req.data == PSC_OFF))
    else $error("write enable not cleared");
  a_pair_addr: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_MEM && pair_second) |=> (dev_req.addr == target + 16'h0001))
    else $error("second byte address wrong");
  a_erase_psc: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_PSC && op_erase) |=> (dev_req.data == PSC_ERASE))
    else $error("erase without both enables");
  a_done_end: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_CCH_OFF) |=> (done && !busy))
    else $error("done not raised at end");
  a_stall_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_WAIT && stall_s2) |=> (state == ST_WAIT))
    else $error("host moved on during device stall");
  a_program_psc: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_PSC && !op_erase) |=> (dev_req.wr && dev_req.sel == SEL_PSC && dev_req.data == PSC_WRITE))
    else $error("program without write enable alone");
  a_pair_cache: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_CACHE && op_pair) |=> (dev_req.wr && dev_req.sel == SEL_CACHE && dev_req.data == CACHE_BLOCK))
    else $error("block write not enabled for pair");
  a_pair_rekey: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_NEXT && op_pair && !pair_second && !bad_key)
      |=> ##1 (dev_req.wr && dev_req.sel == SEL_KEY && dev_req.data == KEY_FIRST))
    else $error("second byte not preceded by keys");
endmodule : nvm_host
`default_nettype wire

// ===== core/nvm_host_pkg.sv
// package: constants and types for the flash programming host controller
package nvm_host_pkg;
  // ************************************************************
  // software-facing register map of the host
  // ************************************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_TARGET = 4'h1;
  localparam logic [3:0] ADDR_DATA   = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_SECOND = 4'h4;
  // ctrl write field positions
  localparam int CTRL_GO_ERASE  = 0;
  localparam int CTRL_GO_WRITE  = 1;
  localparam int CTRL_GO_PAIR   = 2;
  localparam int CTRL_BAD_KEY   = 3;
  // ************************************************************
  // device side register codes and values
  // ************************************************************
  localparam logic [7:0]  KEY_FIRST      = 8'hA5;
  localparam logic [7:0]  KEY_SECOND     = 8'hF1;
  localparam logic [7:0]  KEY_WRONG      = 8'h00;
  localparam logic [7:0]  PSC_WRITE      = 8'h01;
  localparam logic [7:0]  PSC_ERASE      = 8'h03;
  localparam logic [7:0]  PSC_OFF        = 8'h00;
  localparam logic [7:0]  SCALE_TIMING   = 8'h10;
  localparam logic [7:0]  CACHE_BLOCK    = 8'h01;
  localparam logic [7:0]  CACHE_OFF      = 8'h00;
  localparam logic [15:0] SHORT_ADDR_MAX = 16'h00FF;
  localparam int          PAGE_BYTES     = 512;
  localparam logic [2:0]  STALL_GRACE    = 3'h4;

  // device access issued by the host
  typedef enum logic [2:0] {
    SEL_KEY   = 3'h0,
    SEL_PSC   = 3'h1,
    SEL_SCALE = 3'h2,
    SEL_CACHE = 3'h3,
    SEL_MEM   = 3'h4
  } target_sel_t;

  typedef struct packed {
    logic        wr;
    target_sel_t sel;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  data;
  } dev_req_t;

  typedef enum logic [10:0] {
    ST_IDLE    = 11'h001,
    ST_SCALE   = 11'h002,
    ST_CACHE   = 11'h004,
    ST_PSC     = 11'h008,
    ST_KEY1    = 11'h010,
    ST_KEY2    = 11'h020,
    ST_MEM     = 11'h040,
    ST_WAIT    = 11'h080,
    ST_NEXT    = 11'h100,
    ST_PSC_OFF = 11'h200,
    ST_CCH_OFF = 11'h400
  } state_t;
endpackage : nvm_host_pkg

// ===== sim/nvm_dev_model.sv
// file: behavioural flash device model answering the host's write cycles
`timescale 1ns/1ns
`default_nettype none
module nvm_dev_model (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire nvm_host_pkg::dev_req_t dev_req,
  input  wire logic [3:0]             stall_len,
  output logic                        dev_stall
);
  import nvm_host_pkg::*;
  logic [7:0]  mem [0:65535];
  logic [1:0]  key_st;
  logic        lockout;
  logic        psc_we;
  logic        psc_ee;
  logic        blk;
  logic        cached_v;
  logic [15:0] cached_a;
  logic [7:0]  cached_d;
  logic [3:0]  stall_cnt;
  // unerased flash holds a known pattern so a stray erase shows up
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h5A;
  end
  // stall length is set by the bench so the host sees prompt and slow answers
  assign dev_stall = (stall_cnt != 4'h0);
  always @(posedge clock) begin
    if (sys_rst) begin
      {key_st, lockout, psc_we, psc_ee, blk, cached_v, stall_cnt} <= '0;
    end else begin
      if (stall_cnt != 4'h0) stall_cnt <= stall_cnt - 4'h1;
      if (dev_req.wr) begin
        case (dev_req.sel)
          SEL_KEY: begin
            if (key_st == 2'h0 && dev_req.data == KEY_FIRST) key_st <= 2'h1;
            else if (key_st == 2'h1 && dev_req.data == KEY_SECOND) key_st <= 2'h2;
            else begin
              lockout <= 1'b1;
              key_st <= 2'h0;
            end
          end
          SEL_PSC: begin
            psc_we <= dev_req.data[0];
            psc_ee <= dev_req.data[1];
          end
          SEL_CACHE: begin
            blk <= dev_req.data[0];
            if (!dev_req.data[0]) cached_v <= 1'b0; // a lone cached byte is dropped
          end
          SEL_MEM: if (psc_we && (dev_req.wide || dev_req.addr <= SHORT_ADDR_MAX)) begin
            key_st <= 2'h0;
            if (key_st != 2'h2 || lockout) lockout <= 1'b1;
            else if (psc_ee) begin
              for (int i = 0; i < PAGE_BYTES; i++) mem[{dev_req.addr[15:9], 9'(i)}] = 8'hFF;
              stall_cnt <= stall_len;
            end else if (blk && !cached_v) begin
              cached_v <= 1'b1;
              cached_a <= dev_req.addr;
              cached_d <= dev_req.data;
            end else begin
              mem[dev_req.addr] = mem[dev_req.addr] & dev_req.data;
              if (cached_v) mem[cached_a] = mem[cached_a] & cached_d;
              cached_v <= 1'b0;
              stall_cnt <= stall_len;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule : nvm_dev_model
`default_nettype wire

// ===== sim/tb_top.sv
// file: self-checking testbench of the flash programming host
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import nvm_host_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dev_stall, busy;
  logic [3:0] reg_addr = 4'h0, stall_len = 4'h1;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd, a;
  logic [7:0] d, d2, old, old2, last_key;
  dev_req_t dev_req;
  int fails = 0, check_count = 0, cycles = 0;
  nvm_host u_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_req(dev_req), .dev_stall(dev_stall), .busy(busy));
  nvm_dev_model u_dev (.clock(clock), .sys_rst(sys_rst), .dev_req(dev_req), .stall_len(stall_len),
    .dev_stall(dev_stall));
  always #5 clock = ~clock;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task reg_write(input logic [3:0] ad, input logic [15:0] wd);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [3:0] ad, output logic [15:0] q);
    @(posedge clock);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : reg_read
  // runs one operation and waits on busy under a bounded count
  task run_op(input logic [15:0] ctl, input logic [15:0] ta, input logic [7:0] d1, input logic [7:0] ds);
    int n;
    stall_len <= 4'($urandom_range(1, 8));
    reg_write(ADDR_TARGET, ta);
    reg_write(ADDR_DATA, {8'h00, d1});
    reg_write(ADDR_SECOND, {8'h00, ds});
    reg_write(ADDR_CTRL, ctl);
    n = 0;
    #1;
    while (busy !== 1'b0 && n < 500) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 500) begin
      fails++;
      end_sim();
    end
    check("relock", {14'h0, u_dev.key_st}, 16'h0000);
    check("we_off", {15'h0, u_dev.psc_we}, 16'h0000);
  endtask : run_op
  function automatic logic [7:0] prog(input logic [7:0] o, input logic [7:0] v);
    return o & v; // programming only clears bits
  endfunction : prog
  // ************************************************************
  // wire watch and hang limit
  // ************************************************************
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
    if (!sys_rst && dev_req.wr && dev_req.sel == SEL_KEY) last_key <= dev_req.data;
    if (!sys_rst && dev_req.wr && dev_req.sel == SEL_SCALE) begin
      check("scale", {8'h0, dev_req.data}, {8'h0, SCALE_TIMING});
    end
    if (!sys_rst && dev_req.wr && dev_req.sel == SEL_MEM) begin
      check("wide", {15'h0, dev_req.wide}, {15'h0, dev_req.addr > SHORT_ADDR_MAX});
      check("key_order", {8'h0, last_key}, {8'h0, KEY_SECOND});
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'hCA73));
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    reg_read(ADDR_STATUS, rd);
    check("status_rst", rd, 16'h0000);
    reg_read(4'h5, rd);
    check("unmapped", rd, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 16'h0040 : {4'h1 + 4'(k), 3'h0, 9'($urandom)};
      old = u_dev.mem[{a[15:9], 9'h0} - 16'h1];
      run_op(16'h0001, a, 8'($urandom), 8'h00);
      check("erase_lo", {8'h0, u_dev.mem[{a[15:9], 9'h000}]}, 16'h00FF);
      check("erase_hi", {8'h0, u_dev.mem[{a[15:9], 9'h1FF}]}, 16'h00FF);
      check("erase_out", {8'h0, u_dev.mem[{a[15:9], 9'h0} - 16'h1]}, {8'h0, old});
      reg_read(ADDR_STATUS, rd);
      check("status_done", rd, 16'h0002);
    end
    $display("test erase done");
    for (int k = 0; k < 8; k++) begin
      a = (k == 0) ? 16'h0041 : {4'h2, 3'h0, 9'($urandom_range(0, 3))};
      d = 8'($urandom);
      old = u_dev.mem[a];
      run_op(16'h0002, a, d, 8'h00);
      check("program", {8'h0, u_dev.mem[a]}, {8'h0, prog(old, d)});
    end
    $display("test program done");
    a = {4'h3, 3'h0, 9'($urandom_range(8, 510))};
    d = 8'($urandom);
    d2 = 8'($urandom);
    old = u_dev.mem[a];
    old2 = u_dev.mem[a + 16'h1];
    run_op(16'h0004, a, d, d2);
    check("pair_first", {8'h0, u_dev.mem[a]}, {8'h0, prog(old, d)});
    check("pair_second", {8'h0, u_dev.mem[a + 16'h1]}, {8'h0, prog(old2, d2)});
    $display("test pair done");
    a = 16'h2005;
    old = u_dev.mem[a];
    run_op(16'h000A, a, 8'h00, 8'h00);
    check("bad_key_mem", {8'h0, u_dev.mem[a]}, {8'h0, old});
    reg_read(ADDR_STATUS, rd);
    check("violation", {15'h0, rd[2]}, 16'h0001);
    run_op(16'h0002, a, 8'h00, 8'h00);
    check("lockout_mem", {8'h0, u_dev.mem[a]}, {8'h0, old});
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    reg_read(ADDR_STATUS, rd);
    check("status_rst2", rd, 16'h0000);
    run_op(16'h0002, a, 8'h00, 8'h00);
    check("after_reset", {8'h0, u_dev.mem[a]}, 16'h0000);
    $display("test lockout done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
